// File: pkg/dcpf_pkg.sv
// constants and types for the data cache prefetch issue and filter block
// ==========================================================================
// Operation
// - displacement prefetch: base plus displacement, aligned down, whole block requested
// - indexed prefetch: sum of both sources, aligned down, whole block requested
// - block already in data cache: drop without memory access
// - two misses outstanding at issue: drop the prefetch
// - guard supplied: prefetch only when its bit zero is one
// - displacement is a 7-bit modifier, -256 to 252 in steps of four
// - indexed form uses two registers and no modifier
// - opcode 209 is displacement prefetch, 210 is indexed prefetch
// - every prefetch is a hint; dropping alters no architectural state
package dcpf_pkg;

  // ========================================================================
  // widths and decode values
  localparam int         ADDR_W      = 32;
  localparam int         OPC_W       = 8;
  localparam int         SLOT_W      = 3;
  localparam int         MOD_W       = 7;
  localparam int         MOD_SHIFT   = 2;
  localparam logic [7:0] OPC_DISP    = 8'hD1;
  localparam logic [7:0] OPC_INDEX   = 8'hD2;
  localparam logic [2:0] PREF_SLOT   = 3'h5;

  // ========================================================================
  // cache geometry and miss limit
  localparam int          BLOCK_BYTES = 64;
  localparam logic [31:0] BLOCK_MASK  = ~(32'(BLOCK_BYTES) - 32'h1);
  localparam logic [1:0]  MAX_MISSES  = 2'h2;

  // ========================================================================
  // reset values
  localparam logic [31:0] ADDR_RST    = 32'h0;

  typedef enum logic [1:0]
  {
    DCPF_NONE  = 2'b00,
    DCPF_DISP  = 2'b01,
    DCPF_INDEX = 2'b10
  } dcpf_kind_t;

endpackage

// File: test/dcpf_cache_model.sv
// behavioural data cache: remembers the last filled block and reports miss load
`timescale 1ns/1ps
`default_nettype none

module dcpf_cache_model
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        probe_valid,
  input  wire logic [31:0] probe_addr,
  input  wire logic        fill_req,
  input  wire logic [31:0] fill_addr,
  input  wire logic [1:0]  busy_misses,
  output logic             probe_hit,
  output logic [1:0]       misses_outstanding
);
  logic        held;
  logic [31:0] held_addr;

  // ==========================================================================
  // block store
  // remember filled block
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      held      <= 1'b0;
      held_addr <= 32'h0;
    end
    else if (fill_req)
    begin
      held      <= 1'b1;
      held_addr <= fill_addr;
    end
  end

  assign probe_hit          = probe_valid && held && (probe_addr == held_addr);
  assign misses_outstanding = busy_misses;
endmodule
`default_nettype wire

// File: test/tb_dcpf_top.sv
// self-checking bench for the prefetch issue and filter block
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module tb_dcpf_top;
  import dcpf_pkg::*;
  logic        mclk, reset, issue_valid, guard_present, probe_hit, issue_ready;
  logic        probe_valid, fill_req;
  logic [2:0]  issue_slot;
  logic [7:0]  opcode;
  logic [6:0]  modifier;
  logic [1:0]  misses_outstanding, busy_misses;
  logic [31:0] first_source_register, second_source_register, guard_register;
  logic [31:0] probe_addr, fill_addr;
  int          n_fail, checks_done;

  dcpf_top dut (.mclk(mclk), .reset(reset), .issue_valid(issue_valid),
    .issue_slot(issue_slot), .opcode(opcode), .modifier(modifier),
    .first_source_register(first_source_register),
    .second_source_register(second_source_register), .guard_present(guard_present),
    .guard_register(guard_register), .probe_hit(probe_hit),
    .misses_outstanding(misses_outstanding), .issue_ready(issue_ready),
    .probe_valid(probe_valid), .probe_addr(probe_addr), .fill_req(fill_req),
    .fill_addr(fill_addr));
  dcpf_cache_model cache (.mclk(mclk), .reset(reset), .probe_valid(probe_valid),
    .probe_addr(probe_addr), .fill_req(fill_req), .fill_addr(fill_addr),
    .busy_misses(busy_misses), .probe_hit(probe_hit),
    .misses_outstanding(misses_outstanding));

  always #5 mclk = ~mclk;

  // ==========================================================================
  // one issue, then watch four cycles; ep below zero leaves the probe unjudged
  task automatic run_op(input logic [2:0] s, input logic [7:0] op, input logic [6:0] m,
    input logic [31:0] a, b, input logic gp, input logic [31:0] g,
    input logic [1:0] bz, input int ep, ef, input logic [31:0] ea);
    int          np;
    int          nf;
    logic [31:0] pa;
    logic [31:0] fa;
    np = 0;
    nf = 0;
    pa = 32'h0;
    fa = 32'h0;
    {issue_valid, issue_slot, opcode, modifier} = {1'b1, s, op, m};
    {first_source_register, second_source_register} = {a, b};
    {guard_present, guard_register, busy_misses} = {gp, g, bz};
    for (int i = 0; i < 4; i++)
    begin
      @(negedge mclk);
      // release after the first edge, so the prefetch issues at one posedge only and busy_misses returns to zero
      if (i == 0)
        {issue_valid, busy_misses} = {1'b0, 2'h0};
      if (probe_valid === 1'b1) begin np++; pa = probe_addr; end
      if (fill_req === 1'b1) begin nf++; fa = fill_addr; end
      `CHK("issue_ready", 1'b1, issue_ready)
    end
    if (ep >= 0) `CHK("probe count", ep, np)
    `CHK("fill count", ef, nf)
    if (ep > 0) `CHK("probe_addr", ea, pa)
    if (ef > 0) `CHK("fill_addr", ea, fa)
  endtask

  task automatic t_disp();
    run_op(3'h5, 8'hD1, 7'h01, 32'hABFF, 32'h0, 1'b0, 32'h0, 2'h0, 1, 1, 32'hAC00);
    run_op(3'h5, 8'hD1, 7'h40, 32'h1000, 32'h0, 1'b0, 32'h0, 2'h0, 1, 1, 32'h0F00);
    run_op(3'h5, 8'hD1, 7'h3F, 32'h2000, 32'h0, 1'b0, 32'h0, 2'h0, 1, 1, 32'h20C0);
  endtask

  task automatic t_index();
    run_op(3'h5, 8'hD2, 7'h7F, 32'hABCD, 32'hD, 1'b0, 32'h0, 2'h0, 1, 1, 32'hABC0);
    run_op(3'h5, 8'hD2, 7'h0, 32'hABCD, 32'hD, 1'b0, 32'h0, 2'h0, 1, 0, 32'hABC0);
    run_op(3'h5, 8'hD2, 7'h0, 32'hFFFFFFF0, 32'h50, 1'b0, 32'h0, 2'h0, 1, 1, 32'h40);
  endtask

  // reset in mid-run cancels a probe in flight and clears every output
  task automatic t_reset();
    logic [66:0] outs;
    {issue_valid, issue_slot, opcode, modifier} = {1'b1, 3'h5, 8'hD1, 7'h00};
    {first_source_register, guard_present, busy_misses} = {32'h8000, 1'b0, 2'h0};
    @(negedge mclk);
    {issue_valid, reset} = 2'b01;
    repeat (2) @(negedge mclk);
    outs = {issue_ready, probe_valid, probe_addr, fill_req, fill_addr};
    `CHK("outputs in reset", 67'h0, outs)
    reset = 1'b0;
  endtask

  task automatic t_misses();
    run_op(3'h5, 8'hD1, 7'h0, 32'h3000, 32'h0, 1'b0, 32'h0, 2'h2, -1, 0, 32'h3000);
    run_op(3'h5, 8'hD1, 7'h0, 32'h3000, 32'h0, 1'b0, 32'h0, 2'h1, 1, 1, 32'h3000);
  endtask

  task automatic t_guard();
    run_op(3'h5, 8'hD1, 7'h0, 32'h4000, 32'h0, 1'b1, 32'hFFFFFFFE, 2'h0, 0, 0, 32'h0);
    run_op(3'h5, 8'hD2, 7'h0, 32'h4000, 32'h0, 1'b1, 32'h1, 2'h0, 1, 1, 32'h4000);
    run_op(3'h5, 8'hD1, 7'h0, 32'h5000, 32'h0, 1'b0, 32'h0, 2'h0, 1, 1, 32'h5000);
  endtask

  task automatic t_refuse();
    run_op(3'h4, 8'hD1, 7'h0, 32'h6000, 32'h0, 1'b0, 32'h0, 2'h0, 0, 0, 32'h0);
    run_op(3'h5, 8'hD3, 7'h0, 32'h6000, 32'h0, 1'b0, 32'h0, 2'h0, 0, 0, 32'h0);
  endtask

  // two prefetches on consecutive edges; their fills follow one cycle apart
  task automatic t_b2b();
    int          nf;
    logic [31:0] fa [2];
    nf = 0;
    {issue_valid, issue_slot, opcode, modifier} = {1'b1, 3'h5, 8'hD1, 7'h00};
    {first_source_register, second_source_register} = {32'h7000, 32'h0};
    {guard_present, guard_register, busy_misses} = {1'b0, 32'h0, 2'h0};
    @(negedge mclk);
    {opcode, second_source_register} = {8'hD2, 32'h40};
    for (int i = 0; i < 4; i++)
    begin
      @(negedge mclk);
      if (i == 0)
        issue_valid = 1'b0;
      if (fill_req === 1'b1 && nf < 2)
      begin
        fa[nf] = fill_addr;
        nf++;
      end
    end
    `CHK("b2b fill count", 2, nf)
    `CHK("b2b first fill", 32'h7000, fa[0])
    `CHK("b2b second fill", 32'h7040, fa[1])
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    {mclk, reset, issue_valid, issue_slot, opcode, modifier, guard_present} = '0;
    {first_source_register, second_source_register, guard_register} = '0;
    {busy_misses, n_fail, checks_done} = '0;
    reset = 1'b1;
    repeat (10) @(negedge mclk);
    reset = 1'b0;
    t_disp();
    t_index();
    t_reset();
    t_misses();
    t_guard();
    t_refuse();
    t_b2b();
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: verilog/dcpf_addr.sv
// block address former for both prefetch forms
`timescale 1ns/1ps
`default_nettype none

module dcpf_addr
(
  input  wire dcpf_pkg::dcpf_kind_t kind,
  input  wire logic [31:0]          first_source_register,
  input  wire logic [31:0]          second_source_register,
  input  wire logic [6:0]           modifier,
  output logic [31:0]               block_addr
);
  import dcpf_pkg::*;

  logic [31:0] disp;
  logic [31:0] sum;

  // ========================================================================
  // signed modifier scaled by four
  assign disp = {{(ADDR_W - MOD_W - MOD_SHIFT){modifier[MOD_W-1]}}, modifier, 2'b00};

  always_comb
  begin
    sum = ADDR_RST;
    unique case (kind)
      DCPF_DISP:  sum = first_source_register + disp;
      DCPF_INDEX: sum = first_source_register + second_source_register;
      DCPF_NONE:  sum = ADDR_RST;
      default:    sum = ADDR_RST;
    endcase
  end

  // align down to a block boundary
  assign block_addr = sum & BLOCK_MASK;

endmodule

`default_nettype wire

// File: verilog/dcpf_top.sv
// prefetch issue, cache probe and miss-limit filter for the memory special unit
`timescale 1ns/1ps
`default_nettype none

module dcpf_top
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        issue_valid,
  input  wire logic [2:0]  issue_slot,
  input  wire logic [7:0]  opcode,
  input  wire logic [6:0]  modifier,
  input  wire logic [31:0] first_source_register,
  input  wire logic [31:0] second_source_register,
  input  wire logic        guard_present,
  input  wire logic [31:0] guard_register,
  input  wire logic        probe_hit,
  input  wire logic [1:0]  misses_outstanding,
  output logic             issue_ready,
  output logic             probe_valid,
  output logic [31:0]      probe_addr,
  output logic             fill_req,
  output logic [31:0]      fill_addr
);
  import dcpf_pkg::*;

  dcpf_kind_t  kind;
  logic        guard_ok;
  logic        slot_ok;
  logic        cache_busy;
  logic        probe_busy;
  logic [31:0] block_addr;
  logic        next_fill_req;

  // ==========================================================================
  // decode
  // a false guard suppresses the whole prefetch
  assign guard_ok = !guard_present || guard_register[0];
  assign slot_ok  = issue_slot == PREF_SLOT;

  always_comb
  begin
    kind = DCPF_NONE;
    if (issue_valid && slot_ok && guard_ok)
    begin
      if (opcode == OPC_DISP)
        kind = DCPF_DISP;
      else if (opcode == OPC_INDEX)
        kind = DCPF_INDEX;
    end
  end

  // miss count is judged at issue, not when the probe answers
  assign cache_busy = misses_outstanding >= MAX_MISSES;

  dcpf_addr u_addr
  (
    .kind                   (kind),
    .first_source_register  (first_source_register),
    .second_source_register (second_source_register),
    .modifier               (modifier),
    .block_addr             (block_addr)
  );

  // ==========================================================================
  // probe stage
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      probe_valid <= 1'b0;
      probe_addr  <= ADDR_RST;
      probe_busy  <= 1'b0;
    end
    else
    begin
      probe_valid <= kind != DCPF_NONE;
      probe_addr  <= block_addr;
      probe_busy  <= cache_busy;
    end
  end

  // ==========================================================================
  // fill request stage
  // hit or busy cache drops the request quietly
  assign next_fill_req = probe_valid && !probe_hit && !probe_busy;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      fill_req <= 1'b0;
    else
      fill_req <= next_fill_req;
  end

  // drop leaves fill_addr unchanged
  // address only follows a real request, so a dropped block is probed but never reaches fill_addr
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      fill_addr <= ADDR_RST;
    else if (next_fill_req)
      fill_addr <= probe_addr;
  end

  // ==========================================================================
  // issue never waits: a prefetch is a hint and is dropped, not stalled
  // no stall
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      issue_ready <= 1'b0;
    else
      issue_ready <= 1'b1;
  end

  // ==========================================================================
  // assertions
  // shadow of the scaled modifier, kept beside the checks that use it
  logic [31:0] disp_ext;
  logic        pf_issue;

  assign disp_ext = {{(ADDR_W - MOD_W - MOD_SHIFT){modifier[MOD_W-1]}}, modifier, 2'b00};
  assign pf_issue = issue_valid && slot_ok && guard_ok
                    && (opcode == OPC_DISP || opcode == OPC_INDEX);

  // ==========================================================================
  // address checks
  a_disp_addr: assert property (@(posedge mclk) disable iff (reset)
    (issue_valid && slot_ok && guard_ok && opcode == OPC_DISP) |=>
      (probe_valid && probe_addr ==
       (($past(first_source_register) + $past(disp_ext)) & BLOCK_MASK)))
    else $error("displacement prefetch address wrong");

  a_index_addr: assert property (@(posedge mclk) disable iff (reset)
    (issue_valid && slot_ok && guard_ok && opcode == OPC_INDEX) |=>
      (probe_valid && probe_addr == (($past(first_source_register)
       + $past(second_source_register)) & BLOCK_MASK)))
    else $error("indexed prefetch address wrong");

  // the two ends of the displacement range, held against fixed offsets
  a_mod_low: assert property (@(posedge mclk) disable iff (reset)
    (issue_valid && slot_ok && guard_ok && opcode == OPC_DISP && modifier == 7'h40) |=>
      (probe_addr == (($past(first_source_register) - 32'h100) & BLOCK_MASK)))
    else $error("lowest displacement is not minus 256");

  a_mod_high: assert property (@(posedge mclk) disable iff (reset)
    (issue_valid && slot_ok && guard_ok && opcode == OPC_DISP && modifier == 7'h3F) |=>
      (probe_addr == (($past(first_source_register) + 32'hFC) & BLOCK_MASK)))
    else $error("highest displacement is not plus 252");

  a_probe_align: assert property (@(posedge mclk) disable iff (reset)
    probe_valid |-> (probe_addr & ~BLOCK_MASK) == 32'h0)
    else $error("probe address not block aligned");

  // ==========================================================================
  // drop, refusal and miss fill checks
  a_hit_drop: assert property (@(posedge mclk) disable iff (reset)
    (probe_valid && probe_hit) |=> !fill_req)
    else $error("fill requested for a cached block");

  // the miss count is the one seen at issue, two edges before the fill
  a_busy_drop: assert property (@(posedge mclk) disable iff (reset)
    (issue_valid && misses_outstanding == MAX_MISSES) |-> ##2 !fill_req)
    else $error("fill requested with two misses outstanding");

  a_guard_off: assert property (@(posedge mclk) disable iff (reset)
    (guard_present && !guard_register[0]) |=> !probe_valid)
    else $error("guarded-off prefetch issued");

  a_miss_fill: assert property (@(posedge mclk) disable iff (reset)
    (pf_issue && misses_outstanding < MAX_MISSES) ##1 !probe_hit |=> fill_req)
    else $error("missing block not requested");

  a_opcode_only: assert property (@(posedge mclk) disable iff (reset)
    probe_valid |-> ($past(opcode) == OPC_DISP || $past(opcode) == OPC_INDEX))
    else $error("probe from a foreign opcode");

  a_slot_five: assert property (@(posedge mclk) disable iff (reset)
    probe_valid |-> $past(issue_slot) == PREF_SLOT)
    else $error("prefetch accepted outside slot five");

  a_refuse_quiet: assert property (@(posedge mclk) disable iff (reset)
    !pf_issue |=> !probe_valid)
    else $error("probe without an accepted prefetch");

  // ==========================================================================
  // state and stall checks
  a_fill_follows: assert property (@(posedge mclk) disable iff (reset)
    fill_req |-> ($past(probe_valid) && fill_addr == $past(probe_addr)
                  && fill_addr[5:0] == 6'h0))
    else $error("fill without a probe behind it");

  a_drop_keep: assert property (@(posedge mclk) disable iff (reset)
    (probe_valid && probe_hit) |=> $stable(fill_addr))
    else $error("dropped prefetch changed the fill address");

  a_no_stall: assert property (@(posedge mclk) disable iff (reset)
    $past(issue_ready) |-> issue_ready)
    else $error("issue stalled");

  a_ready_up: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) |-> issue_ready)
    else $error("issue not ready after reset");

  // ==========================================================================
  // cover points
  c_fill: cover property (@(posedge mclk) disable iff (reset)
    probe_valid ##1 fill_req);
  c_hit: cover property (@(posedge mclk) disable iff (reset)
    probe_valid && probe_hit);
  c_busy: cover property (@(posedge mclk) disable iff (reset)
    probe_valid && probe_busy);
  c_b2b: cover property (@(posedge mclk) disable iff (reset)
    fill_req ##1 fill_req);
  c_guard_on: cover property (@(posedge mclk) disable iff (reset)
    (issue_valid && guard_present && guard_register[0]) ##1 probe_valid);

endmodule

`default_nettype wire
